// *** hdl/isb_params.svh ***
`ifndef ISB_PARAMS_SVH
`define ISB_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define ISB_CLK_PERIOD_NS 10
`define ISB_HOLD_LONG_NS 300
`define ISB_HOLD_SHORT_NS 100

// ****************************************
// Byte framing and address layout
// ****************************************
`define ISB_CNT_ACK 4'h8
`define ISB_CNT_DONE 4'h9
`define ISB_CNT_LAST_DATA 4'h7
`define ISB_TEN_PREFIX 5'h1E
`define ISB_TEN_HI_MSB 2
`define ISB_TEN_HI_LSB 1
`define ISB_RW_BIT 0

// ****************************************
// Reset values
// ****************************************
`define ISB_BYTE_RST 8'h00
`define ISB_CNT_RST 4'h0
`define ISB_HOLD_RST 6'h00

`endif

// *** hdl/isb_pkg.sv ***
package isb_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_ADLO = 5'h04,
        ST_RX = 5'h08,
        ST_TX = 5'h10
    } isb_state_e;

    typedef enum logic [1:0] {
        MODE_7BIT = 2'h0,
        MODE_10BIT = 2'h1,
        MODE_7BIT_SS = 2'h2,
        MODE_10BIT_SS = 2'h3
    } isb_mode_e;

    typedef logic [7:0] isb_byte_t;

endpackage : isb_pkg

// *** hdl/isb_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Sampled bits crossing from the link clock
// ****************************************
interface isb_link_if;
    logic bit_toggle;
    logic [7:0] word;

    modport sampler (output bit_toggle, output word);
    modport ctrl (input bit_toggle, input word);
endinterface : isb_link_if

`default_nettype wire

// *** hdl/isb_bit_sampler.sv ***
`timescale 1ns/100ps
`default_nettype none

module isb_bit_sampler
    import isb_pkg::*;
(
    // Link clock and reset
    input wire logic scl_clk_in,
    input wire logic rst_in,
    // Data pin
    input wire logic sda_in,
    // Toward the system clock side
    isb_link_if.sampler link
);

    logic [7:0] shift_reg;
    logic toggle_reg;

    // Word is stable while SCL is low, so the far side reads it after the toggle lands
    always_ff @(posedge scl_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_reg <= 8'h00;
            toggle_reg <= 1'b0;
        end else begin
            shift_reg <= {shift_reg[6:0], sda_in}; // RULE_26
            toggle_reg <= ~toggle_reg;
        end
    end

    assign link.word = shift_reg;
    assign link.bit_toggle = toggle_reg;

endmodule : isb_bit_sampler

`default_nettype wire

// *** hdl/isb_slave_core.sv ***
// Notes on behaviour
// (RULE_01) Enabled port makes pins open drain, pull-low only
// (RULE_02) Hold select stretches SDA hold to 300 ns
// (RULE_03) SDA falling while SCL high is Start
// (RULE_04) Idle only when unowned and both lines high
// (RULE_05) SDA low while we release it is collision
// (RULE_06) Start seen while we transmit is collision
// (RULE_07) SDA rising while SCL high is Stop
// (RULE_08) Stop needs one SCL low since Start
// (RULE_09) Restart resets slave state like Start
// (RULE_10) 10-bit read needs prior match; then stretch
// (RULE_11) Prior match kept until Stop, write, mismatch
// (RULE_12) Start/Stop enables add interrupts in plain modes
// (RULE_13) Ninth pulse carries acknowledge; transmitter releases SDA
// (RULE_14) Ninth pulse level stored as ack received
// (RULE_15) Hold enables let software choose ack level
// (RULE_16) Hold enables clear give automatic ack
// (RULE_17) Full buffer or overflow withholds the ack
// (RULE_18) Ack-time flag after eighth fall, hold only
// (RULE_19) Mode field picks four slave modes
// (RULE_20) Matching first byte loads buffer, raises interrupt
// (RULE_21) Mismatch returns idle with no flags
// (RULE_22) Address mask gates compared bit positions
// (RULE_23) Read direction transmits every byte until end
// (RULE_24) Seven-bit mode ignores address LSB
// (RULE_25) Ten-bit high byte compared to 11110 A9 A8
// (RULE_26) SDA sampled on SCL rising edge
// (RULE_27) Each data byte sets interrupt until cleared; a transmitted byte the master NACKs sets none
// (RULE_28) SCL and SDA pass two-flop synchronisers
`timescale 1ns/100ps
`default_nettype none
`include "isb_params.svh"

module isb_slave_core
    import isb_pkg::*;
(
    // Clocks and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic scl_clk_in,
    // Bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Configuration
    input wire logic port_enable_bit_in,
    input wire logic [1:0] port_mode_field_in,
    input wire logic data_hold_select_in,
    input wire logic address_hold_enable_in,
    input wire logic data_hold_enable_in,
    input wire logic ack_value_bit_in,
    input wire logic start_irq_enable_in,
    input wire logic stop_irq_enable_in,
    input wire logic [7:0] slave_address_register_in,
    input wire logic [7:0] slave_address_low_in,
    input wire logic [7:0] address_mask_in,
    input wire logic [7:0] tx_data_in,
    // Software strobes
    input wire logic buffer_read_in,
    input wire logic overflow_clear_in,
    input wire logic irq_clear_in,
    input wire logic clock_release_in,
    // Status
    output logic [7:0] shift_buffer_register_out,
    output logic buffer_full_flag_out,
    output logic receive_overflow_flag_out,
    output logic ack_received_bit_out,
    output logic ack_time_flag_out,
    output logic port_irq_flag_out,
    output logic bus_collision_out,
    output logic bus_idle_out,
    output logic read_dir_out,
    output logic prior_match_out
);

    // ****************************************
    // Timing counts
    // ****************************************
    localparam int HOLD_LONG_CYC = (`ISB_HOLD_LONG_NS + `ISB_CLK_PERIOD_NS - 1) / `ISB_CLK_PERIOD_NS;
    localparam int HOLD_SHORT_CYC = (`ISB_HOLD_SHORT_NS + `ISB_CLK_PERIOD_NS - 1) / `ISB_CLK_PERIOD_NS;

    function automatic logic masked_eq(input isb_byte_t a, input isb_byte_t b, input isb_byte_t m);
        masked_eq = ((a ^ b) & m) == 8'h00;
    endfunction : masked_eq

    // ****************************************
    // Link sampler and crossing
    // ****************************************
    isb_link_if link ();

    isb_bit_sampler u_sampler (
        .scl_clk_in(scl_clk_in),
        .rst_in(rst_in),
        .sda_in(sda_in),
        .link(link)
    );

    logic scl_m_reg, scl_s_reg, scl_p_reg;
    logic sda_m_reg, sda_s_reg, sda_p_reg;
    logic tog_m_reg, tog_s_reg, tog_p_reg;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {scl_m_reg, scl_s_reg, scl_p_reg} <= 3'h7;
            {sda_m_reg, sda_s_reg, sda_p_reg} <= 3'h7;
            {tog_m_reg, tog_s_reg, tog_p_reg} <= 3'h0;
        end else begin
            {scl_m_reg, scl_s_reg, scl_p_reg} <= {scl_in, scl_m_reg, scl_s_reg}; // RULE_28
            {sda_m_reg, sda_s_reg, sda_p_reg} <= {sda_in, sda_m_reg, sda_s_reg}; // RULE_28
            {tog_m_reg, tog_s_reg, tog_p_reg} <= {link.bit_toggle, tog_m_reg, tog_s_reg};
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    isb_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic active_reg, active_next;
    logic low_seen_reg, low_seen_next;
    logic prior_reg, prior_next;
    logic ack_go_reg, ack_go_next;
    logic ovf_reg, ovf_next;
    logic is_addr_reg, is_addr_next;
    logic pend_reg, pend_next;
    logic [5:0] hold_reg, hold_next;
    logic drive_reg, drive_next;
    logic scl_hold_reg, scl_hold_next;
    isb_byte_t tx_reg, tx_next;
    isb_byte_t buf_reg, buf_next;
    logic bf_reg, bf_next;
    logic ov_reg, ov_next;
    logic ackr_reg, ackr_next;
    logic ackt_reg, ackt_next;
    logic irq_reg, irq_next;
    logic coll_reg, coll_next;
    logic idle_reg, rw_reg, rw_next;

    // ****************************************
    // Conditions and decode
    // ****************************************
    wire en = port_enable_bit_in;
    wire start_det = en & scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg; // RULE_03
    wire stop_det = en & scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg & low_seen_reg; // RULE_07 RULE_08
    wire fall_ev = en & active_reg & scl_p_reg & ~scl_s_reg;
    wire rise_ev = en & active_reg & (tog_s_reg ^ tog_p_reg);
    wire ten_bit = port_mode_field_in[0]; // RULE_19
    wire ss_mode = port_mode_field_in[1]; // RULE_19
    wire hold_sel = is_addr_reg ? address_hold_enable_in : data_hold_enable_in;
    wire any_hold = address_hold_enable_in | data_hold_enable_in;
    wire [5:0] hold_load = data_hold_select_in ? 6'(HOLD_LONG_CYC) : 6'(HOLD_SHORT_CYC); // RULE_02
    isb_byte_t rx_byte;
    assign rx_byte = link.word;
    wire rw_bit = rx_byte[`ISB_RW_BIT];
    wire match7 = masked_eq({rx_byte[7:1], 1'b0}, {slave_address_register_in[7:1], 1'b0},
        address_mask_in); // RULE_22 RULE_24
    wire match_hi = (rx_byte[7:3] == `ISB_TEN_PREFIX) &
        masked_eq({5'h00, rx_byte[`ISB_TEN_HI_MSB:`ISB_TEN_HI_LSB], 1'b0},
        {5'h00, slave_address_register_in[`ISB_TEN_HI_MSB:`ISB_TEN_HI_LSB], 1'b0}, address_mask_in); // RULE_25
    wire match_lo = masked_eq(rx_byte, slave_address_low_in, address_mask_in); // RULE_22
    wire byte_end = rise_ev & (cnt_reg == `ISB_CNT_LAST_DATA);
    wire ack_pulse = rise_ev & (cnt_reg == `ISB_CNT_ACK);

    // ****************************************
    // Slave sequencing
    // ****************************************
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        active_next = active_reg;
        low_seen_next = low_seen_reg;
        prior_next = prior_reg;
        ack_go_next = ack_go_reg;
        ovf_next = ovf_reg;
        is_addr_next = is_addr_reg;
        pend_next = pend_reg;
        hold_next = (hold_reg != 6'h00) ? hold_reg - 6'h01 : hold_reg;
        drive_next = (hold_reg == 6'h01) ? pend_reg & en : drive_reg & en; // RULE_01
        scl_hold_next = scl_hold_reg & en;
        tx_next = tx_reg;
        buf_next = buf_reg;
        bf_next = bf_reg & ~buffer_read_in;
        ov_next = ov_reg & ~overflow_clear_in;
        ackr_next = ackr_reg;
        ackt_next = ackt_reg;
        irq_next = irq_reg & ~irq_clear_in;
        coll_next = coll_reg;
        rw_next = rw_reg;
        if (rise_ev && cnt_reg < `ISB_CNT_DONE) begin
            cnt_next = cnt_reg + 4'h1;
        end
        if (rise_ev && state_reg == ST_TX && !drive_reg && !rx_byte[0] && cnt_reg < `ISB_CNT_ACK) begin
            coll_next = 1'b1; // RULE_05
            state_next = ST_IDLE;
        end
        if (byte_end) begin
            ovf_next = bf_reg | ov_reg;
            ack_go_next = 1'b0;
            is_addr_next = (state_reg == ST_ADDR) | (state_reg == ST_ADLO);
            case (state_reg)
                ST_ADDR: begin
                    if (!ten_bit && match7) begin
                        ack_go_next = 1'b1;
                        rw_next = rw_bit;
                        state_next = rw_bit ? ST_TX : ST_RX; // RULE_23
                    end else if (ten_bit && match_hi && !rw_bit) begin
                        ack_go_next = 1'b1;
                        prior_next = 1'b0; // RULE_11
                        rw_next = 1'b0;
                        state_next = ST_ADLO;
                    end else if (ten_bit && match_hi && prior_reg) begin
                        ack_go_next = 1'b1;
                        rw_next = 1'b1;
                        state_next = ST_TX; // RULE_10
                    end else begin
                        prior_next = prior_reg & ~ten_bit; // RULE_11
                        state_next = ST_IDLE; // RULE_21
                    end
                end
                ST_ADLO: begin
                    ack_go_next = match_lo;
                    prior_next = match_lo; // RULE_11
                    state_next = match_lo ? ST_RX : ST_IDLE; // RULE_21
                end
                ST_RX: begin
                    ack_go_next = 1'b1;
                end
                default: begin
                    ack_go_next = 1'b0;
                end
            endcase
            if (ack_go_next && state_reg != ST_TX) begin
                if (bf_reg) begin
                    ov_next = 1'b1;
                end else begin
                    buf_next = rx_byte; // RULE_20
                    bf_next = 1'b1;
                end
                irq_next = 1'b1; // RULE_20 RULE_27
            end
        end
        if (ack_pulse) begin
            ackr_next = rx_byte[0]; // RULE_14
            if (state_reg == ST_TX && !ack_go_reg && rx_byte[0]) begin
                state_next = ST_IDLE;
            end
        end
        if (fall_ev) begin
            low_seen_next = 1'b1;
            hold_next = hold_load; // RULE_02
            pend_next = 1'b0;
            if (cnt_reg == `ISB_CNT_ACK) begin
                pend_next = ack_go_reg & ~ovf_reg & ~(hold_sel & ack_value_bit_in); // RULE_15 RULE_16 RULE_17
                ackt_next = (ack_go_reg | state_reg == ST_TX) & any_hold; // RULE_18
            end else if (cnt_reg == `ISB_CNT_DONE) begin
                cnt_next = `ISB_CNT_RST;
                ackt_next = 1'b0;
                ack_go_next = 1'b0;
                if (state_reg == ST_TX) begin
                    scl_hold_next = 1'b1; // RULE_10
                    irq_next = 1'b1; // RULE_27
                end
            end else if (state_reg == ST_TX && !scl_hold_reg) begin
                pend_next = ~tx_reg[7];
                tx_next = {tx_reg[6:0], 1'b0};
            end
            if (state_reg == ST_TX && cnt_reg == `ISB_CNT_ACK && !ack_go_reg) begin
                pend_next = 1'b0; // RULE_13
            end
        end
        if (clock_release_in && scl_hold_reg) begin
            scl_hold_next = 1'b0;
            pend_next = ~tx_data_in[7];
            tx_next = {tx_data_in[6:0], 1'b0};
            hold_next = hold_load;
        end
        if (start_det) begin
            coll_next = coll_reg | (state_reg == ST_TX) | drive_reg; // RULE_06
            active_next = 1'b1;
            state_next = ST_ADDR; // RULE_09
            cnt_next = `ISB_CNT_RST;
            low_seen_next = 1'b0;
            ack_go_next = 1'b0;
            ackt_next = 1'b0;
            pend_next = 1'b0;
            hold_next = `ISB_HOLD_RST;
            drive_next = 1'b0;
            scl_hold_next = 1'b0;
        end
        if (stop_det) begin
            active_next = 1'b0;
            state_next = ST_IDLE;
            prior_next = 1'b0; // RULE_11
            ackt_next = 1'b0;
            pend_next = 1'b0;
            hold_next = `ISB_HOLD_RST;
            drive_next = 1'b0;
            scl_hold_next = 1'b0;
        end
        if ((start_det && (ss_mode || start_irq_enable_in)) || (stop_det && (ss_mode || stop_irq_enable_in))) begin
            irq_next = 1'b1; // RULE_12 RULE_19
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `ISB_CNT_RST;
            {active_reg, low_seen_reg, prior_reg, ack_go_reg, ovf_reg, is_addr_reg} <= 6'h00;
            {pend_reg, drive_reg, scl_hold_reg, bf_reg, ov_reg, ackr_reg} <= 6'h00;
            {ackt_reg, irq_reg, coll_reg, rw_reg} <= 4'h0;
            idle_reg <= 1'b1;
            hold_reg <= `ISB_HOLD_RST;
            tx_reg <= `ISB_BYTE_RST;
            buf_reg <= `ISB_BYTE_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            {active_reg, low_seen_reg, prior_reg} <= {active_next, low_seen_next, prior_next};
            {ack_go_reg, ovf_reg, is_addr_reg} <= {ack_go_next, ovf_next, is_addr_next};
            {pend_reg, drive_reg, scl_hold_reg} <= {pend_next, drive_next, scl_hold_next};
            {bf_reg, ov_reg, ackr_reg} <= {bf_next, ov_next, ackr_next};
            {ackt_reg, irq_reg, coll_reg, rw_reg} <= {ackt_next, irq_next, coll_next, rw_next};
            idle_reg <= ~active_next & scl_s_reg & sda_s_reg; // RULE_04
            hold_reg <= hold_next;
            tx_reg <= tx_next;
            buf_reg <= buf_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Pins only ever pull low; the line level comes from the enable
    assign sda_out = 1'b0; // RULE_01
    assign scl_out = 1'b0; // RULE_01
    assign sda_oe_out = drive_reg;
    assign scl_oe_out = scl_hold_reg;
    assign shift_buffer_register_out = buf_reg;
    assign buffer_full_flag_out = bf_reg;
    assign receive_overflow_flag_out = ov_reg;
    assign ack_received_bit_out = ackr_reg;
    assign ack_time_flag_out = ackt_reg;
    assign port_irq_flag_out = irq_reg;
    assign bus_collision_out = coll_reg;
    assign bus_idle_out = idle_reg;
    assign read_dir_out = rw_reg;
    assign prior_match_out = prior_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_addr_byte_end;
        byte_end && state_reg == ST_ADDR;
    endsequence
    sequence s_ack_fall;
        fall_ev && cnt_reg == `ISB_CNT_ACK;
    endsequence

    a_start_to_addr: assert property (start_det |=> state_reg == ST_ADDR && cnt_reg == 4'h0) // RULE_03
        else $error("start did not arm address phase");
    a_stop_after_low: assert property (en && scl_s_reg && scl_p_reg && !sda_p_reg && sda_s_reg |=> // RULE_08
        active_reg == ($past(active_reg) && !$past(low_seen_reg)))
        else $error("stop accepted without scl low");
    a_idle_levels: assert property (bus_idle_out |-> !active_reg && $past(scl_s_reg) && $past(sda_s_reg)) // RULE_04
        else $error("idle with line low or bus owned");
    a_mismatch_quiet: assert property (s_addr_byte_end ##0 (!ten_bit && !match7) |=> // RULE_21
        state_reg == ST_IDLE && !bf_reg && (irq_reg == $past(irq_reg & ~irq_clear_in)))
        else $error("mismatch left visible trace");
    a_ack_auto: assert property (s_ack_fall ##0 (ack_go_reg && !ovf_reg && !hold_sel) |=> pend_reg) // RULE_16
        else $error("automatic ack not scheduled");
    a_ack_withhold: assert property (s_ack_fall ##0 ovf_reg |=> !pend_reg) // RULE_17
        else $error("ack given while full or overflowed");
    a_ack_time_flag: assert property (s_ack_fall ##0 (ack_go_reg && any_hold) |=> ack_time_flag_out) // RULE_18
        else $error("ack time flag missing");
    a_ack_stored: assert property (ack_pulse |=> ack_received_bit_out == $past(rx_byte[0])) // RULE_14
        else $error("ack level not stored");
    a_hold_steady: assert property (hold_reg > 6'h01 && !start_det && !stop_det |=> $stable(drive_reg)) // RULE_02
        else $error("sda changed inside hold time");
    a_prior_stop: assert property (stop_det |=> !prior_match_out) // RULE_11
        else $error("prior match survived stop");
    a_open_drain: assert property (sda_oe_out |-> $past(port_enable_bit_in)) // RULE_01
        else $error("sda driven while port disabled");

endmodule : isb_slave_core

`default_nettype wire

// *** verif/isb_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module isb_master_model
    import isb_pkg::*;
(
    // Bit tick and wire levels
    input wire logic tick_in,
    input wire logic scl_in,
    input wire logic sda_in,
    // Pull-low drivers
    output logic scl_low_out,
    output logic sda_low_out
);
    // ****************************************
    // Master, pull-low only; pull-ups on both wires
    // ****************************************
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end

    task automatic half(input int n);
        repeat (n) @(posedge tick_in);
    endtask : half

    // SDA let go well before SCL so a late ack cannot pose as a Stop
    task automatic start;
        sda_low_out = 1'b0;
        half(3);
        scl_low_out = 1'b0;
        wait (scl_in === 1'b1);
        half(3);
        sda_low_out = 1'b1;
        half(3);
        scl_low_out = 1'b1;
    endtask : start

    task automatic stop;
        sda_low_out = 1'b1;
        half(3);
        scl_low_out = 1'b0;
        wait (scl_in === 1'b1);
        half(3);
        sda_low_out = 1'b0;
        half(3);
    endtask : stop

    // Bit 0 is the ack slot; a one releases SDA
    task automatic byte_io(input logic [8:0] o, output logic [8:0] i);
        for (int b = 8; b >= 0; b--) begin
            half(1);
            sda_low_out = ~o[b];
            half(2);
            scl_low_out = 1'b0;
            wait (scl_in === 1'b1);
            half(2);
            i[b] = sda_in;
            half(1);
            scl_low_out = 1'b1;
        end
    endtask : byte_io
endmodule : isb_master_model

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import isb_pkg::*;
;
    logic clk, tck, rst, en, hsel, address_hold_enable, data_hold_enable, ackv, sie, pie, atf_seen;
    logic [1:0] mode;
    logic [3:0] stb;
    isb_byte_t sadr, slo, msk, txd, buf_q;
    logic bf, ov, ackr, atf, irq, bcol, idle, rdir, pm, scl_oe, sda_oe, so, dout, m_scl, m_sda;
    logic [8:0] rx;
    int fails, checks;
    wire logic scl_w, sda_w;
    // Pull-ups: a released wire reads high
    assign scl_w = ~(m_scl | scl_oe);
    assign sda_w = ~(m_sda | sda_oe);

    isb_slave_core i_dut (.ref_clk_in(clk), .rst_in(rst), .scl_clk_in(scl_w), .scl_in(scl_w),
        .scl_out(so), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(dout), .sda_oe_out(sda_oe),
        .port_enable_bit_in(en), .port_mode_field_in(mode), .data_hold_select_in(hsel),
        .address_hold_enable_in(address_hold_enable), .data_hold_enable_in(data_hold_enable), .ack_value_bit_in(ackv),
        .start_irq_enable_in(sie), .stop_irq_enable_in(pie), .slave_address_register_in(sadr),
        .slave_address_low_in(slo), .address_mask_in(msk), .tx_data_in(txd),
        .buffer_read_in(stb[3]), .overflow_clear_in(stb[2]), .irq_clear_in(stb[1]),
        .clock_release_in(stb[0]), .shift_buffer_register_out(buf_q), .buffer_full_flag_out(bf),
        .receive_overflow_flag_out(ov), .ack_received_bit_out(ackr), .ack_time_flag_out(atf),
        .port_irq_flag_out(irq), .bus_collision_out(bcol), .bus_idle_out(idle),
        .read_dir_out(rdir), .prior_match_out(pm));
    isb_master_model i_mst (.tick_in(tck), .scl_in(scl_w), .sda_in(sda_w),
        .scl_low_out(m_scl), .sda_low_out(m_sda));

    // ****************************************
    // Clocks, helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Link tick offset so its edges never meet the system clock
    initial begin
        tck = 1'b0;
        #37;
        forever #80 tck = ~tck;
    end
    always @(negedge clk) begin
        if (atf === 1'b1) atf_seen = 1'b1;
    end

    task automatic wrap_up;
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Pin edges reach the flags only after the synchronisers
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask : settle

    task automatic pulse(input logic [3:0] s);
        @(posedge clk);
        stb <= s;
        @(posedge clk);
        stb <= 4'h0;
    endtask : pulse

    task automatic wait_stretch;
        for (int n = 0; n < 3000 && scl_oe !== 1'b1; n++) @(negedge clk);
        chk(scl_oe, 1'b1);
    endtask : wait_stretch

    task automatic send(input isb_byte_t d);
        i_mst.byte_io({d, 1'b1}, rx);
        settle();
    endtask : send

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_write;
        @(posedge clk);
        sadr <= 8'hA4;
        hsel <= 1'b1;
        atf_seen = 1'b0;
        i_mst.start();
        settle();
        chk(idle, 1'b0);
        send(8'hA4);
        chk({rx[0], bf, irq, rdir, buf_q}, 12'h6A4);
        send(8'h3C);
        chk({rx[0], ov, buf_q}, 12'h3A4);
        i_mst.stop();
        settle();
        chk({idle, atf_seen}, 2'h2);
        pulse(4'hE);
        settle();
        chk({bf, ov, irq}, 3'h0);
    endtask : sc_write

    task automatic sc_mask;
        @(posedge clk);
        sadr <= 8'hB4;
        i_mst.start();
        send(8'hA4);
        chk({rx[0], bf, irq}, 3'h4);
        i_mst.stop();
        @(posedge clk);
        msk <= 8'hEF;
        i_mst.start();
        send(8'hA4);
        chk({rx[0], bf, buf_q}, 12'h1A4);
        i_mst.stop();
        pulse(4'hE);
    endtask : sc_mask

    task automatic sc_hold;
        @(posedge clk);
        {address_hold_enable, ackv} <= 2'h3;
        sadr <= 8'hA4;
        msk <= 8'hFF;
        atf_seen = 1'b0;
        i_mst.start();
        send(8'hA4);
        chk({rx[0], atf_seen}, 2'h3);
        i_mst.stop();
        pulse(4'hE);
        {address_hold_enable, ackv} <= 2'h0;
    endtask : sc_hold

    task automatic sc_read;
        @(posedge clk);
        sie <= 1'b1;
        txd <= 8'h96;
        i_mst.start();
        settle();
        chk(irq, 1'b1);
        pulse(4'h2);
        send(8'hA5);
        wait_stretch();
        chk({rx[0], rdir, irq}, 3'h3);
        pulse(4'h1);
        send(8'hFF);
        chk({rx[8:1], ackr}, 12'h12D);
        i_mst.stop();
        pulse(4'hE);
        sie <= 1'b0;
    endtask : sc_read

    task automatic sc_ten;
        @(posedge clk);
        mode <= MODE_10BIT_SS;
        txd <= 8'hC3;
        sadr <= 8'h04;
        slo <= 8'h5A;
        i_mst.start();
        settle();
        chk(irq, 1'b1);
        pulse(4'hE);
        send(8'hF4);
        chk(rx[0], 1'b0);
        pulse(4'hE);
        send(8'h5A);
        chk({rx[0], pm}, 2'h1);
        pulse(4'hE);
        i_mst.start();
        send(8'hF5);
        wait_stretch();
        chk({rx[0], rdir}, 2'h1);
        pulse(4'h1);
        send(8'hFF);
        chk(rx[8:1], 8'hC3);
        i_mst.stop();
        settle();
        chk({pm, bcol}, 2'h0);
    endtask : sc_ten

    // Collision flag is sticky, so this runs last and ends in a reset
    task automatic sc_coll;
        pulse(4'hE);
        mode <= MODE_7BIT;
        pie <= 1'b1;
        sadr <= 8'hA4;
        txd <= 8'hFF;
        i_mst.start();
        send(8'hA5);
        wait_stretch();
        pulse(4'h1);
        send(8'h7F);
        chk({bcol, rdir}, 2'h3);
        pulse(4'h2);
        i_mst.stop();
        settle();
        chk(irq, 1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk({bcol, idle, irq}, 3'h2);
    endtask : sc_coll

    initial begin
        fails = 0;
        checks = 0;
        {rst, en, hsel, address_hold_enable, data_hold_enable, ackv, sie, pie, atf_seen} = 9'h100;
        {sadr, slo, txd} = 24'h0;
        msk = 8'hFF;
        stb = 4'h0;
        mode = MODE_7BIT;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        en <= 1'b1;
        settle();
        chk({idle, bf, irq, sda_oe, scl_oe, so, dout}, 7'h40);
        sc_write();
        sc_mask();
        sc_hold();
        sc_read();
        sc_ten();
        sc_coll();
        wrap_up();
    end

    initial begin
        #800000;
        fails++;
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
